// [shared/tcctl_pkg.sv]
/*
 Shared constants and types for the trace capture control registers.
 Assumes a TAP data path that presents one register access per update.
*/
`default_nettype none
package tcctl_pkg;
  // TAP register numbers
  localparam logic [7:0] TCCTL_ADDR_CORE_CTL = 8'h10;
  localparam logic [7:0] TCCTL_ADDR_OUT_CTL = 8'h11;
  localparam logic [7:0] TCCTL_ADDR_DATA = 8'h12;
  // Indirect register numbers
  localparam logic [4:0] TCCTL_SEL_CONFIG = 5'h00;
  localparam logic [4:0] TCCTL_SEL_TW = 5'h04;
  localparam logic [4:0] TCCTL_SEL_RDP = 5'h05;
  localparam logic [4:0] TCCTL_SEL_WRP = 5'h06;
  localparam logic [4:0] TCCTL_SEL_STP = 5'h07;
  // core_trace_input_control fields
  localparam int TCCTL_A_ON = 0;
  localparam int TCCTL_A_MODE_LO = 1;
  localparam int TCCTL_A_SUPP_LO = 24;
  // trace_output_control fields
  localparam int TCCTL_B_WE = 31;
  localparam int TCCTL_B_SEL_LO = 21;
  localparam int TCCTL_B_WR = 20;
  localparam int TCCTL_B_RM = 16;
  localparam int TCCTL_B_TR = 15;
  localparam int TCCTL_B_BF = 14;
  localparam int TCCTL_B_FILL_LO = 12;
  localparam int TCCTL_B_CR_LO = 8;
  localparam int TCCTL_B_CAL = 7;
  localparam int TCCTL_B_CA = 2;
  localparam int TCCTL_B_OFC = 1;
  localparam int TCCTL_B_EN = 0;
  // Reset values and full trace mode
  localparam logic [2:0] TCCTL_CR_RESET = 3'h4;
  localparam logic [2:0] TCCTL_MODE_RESET = 3'h0;
  localparam logic [2:0] TCCTL_MODE_FULL = 3'h7;
  // Configuration register fields (revision is 0) and pointer byte shift
  localparam int TCCTL_CFG_SZ_LO = 17;
  localparam int TCCTL_CFG_ONT = 5;
  localparam int TCCTL_CFG_OFT = 4;
  localparam int TCCTL_PTR_SHIFT = 3;
  // Stall record identification
  localparam logic [3:0] TCCTL_TYPE1 = 4'h1;
  localparam logic [3:0] TCCTL_TYPE6 = 4'h6;
  localparam logic [3:0] TCCTL_SUB_STALL_A = 4'h1;
  localparam logic [3:0] TCCTL_SUB_STALL_B = 4'h5;
  // Stop record emitted when a stop trigger ends tracing
  localparam logic [63:0] TCCTL_STOP_WORD = 64'h0000_0000_0000_0036;
  localparam int TCCTL_CAL_LEN = 8;

  typedef enum logic [1:0] {
    TCCTL_FILL_TO = 2'b00,
    TCCTL_FILL_FROM = 2'b01
  } tcctl_fill_t;

  typedef enum logic [1:0] {
    TCCTL_IDLE = 2'b00,
    TCCTL_RUN = 2'b01,
    TCCTL_STOPREC = 2'b10
  } tcctl_state_t;

  typedef struct packed {
    logic [3:0] rec_type;
    logic [3:0] subcode;
    logic multipipe;
    logic [63:0] word;
  } tcctl_rec_t;
endpackage
`default_nettype wire

// [src/tcctl_regs.sv]
/*
 Trace capture control registers with on-chip trace memory, record filter,
 two-entry buffer, off-chip stream, trace clock divider and calibration.
 Assumes TAP updates and core trace records are synchronous to clock.
*/
// Function
// - Mode 111 traces PC, addresses, data
// - Bit 0 drives core trace-on, reset 0
// - Bit 31 gates writes, reads zero
// - Bits 25:21 select indirect register
// - Bit 20 permits indirect writes
// - Read side effect on permitted write documented
// - Read-memory start loads oldest pointer
// - Each trace-word read increments read pointer
// - Reaching write pointer clears read-memory bit
// - Memory reset zeroes pointers, self-clears
// - Buffer-full flags full trace-from memory
// - Bits 13:12 select fill mode
// - Trace-to mode wraps overwriting oldest
// - Trace-from fills from tracing-active until full
// - Bits 10:8 clock ratio, reset 100
// - Clock ratio encoding table
// - Calibrate emits repeating pattern per nibble
// - Cycle-accurate off drops stalls, clears bit0
// - Stall records are type6 0001/0101, type1 (type1 only when not multipipe)
// - Target select picks off-chip or on-chip
// - Master enable by write or triggers
// - Enable low: ignore core, stop record, flush (stop record only on stop trigger, not on enable write)
// - Reserved fields read zero
// - Indirect writes need write permission
// - Read pointer wraps at memory top
`timescale 1ns/1ps
`default_nettype none
module tcctl_regs #(
  parameter int DEPTH = 32,
  parameter int PINS = 4,
  parameter bit ONCHIP = 1'b1,
  parameter bit OFFCHIP = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // TAP data path
  input wire logic tap_update,
  input wire logic [7:0] tap_addr,
  input wire logic [63:0] tap_wdata,
  output logic [63:0] tap_rdata,
  output logic tap_rvalid,
  // Core trace controls
  input wire logic [1:0] supported_modes,
  output logic [2:0] core_trace_mode_input,
  output logic core_trace_on_input,
  // Core trace records
  input wire logic core_tracing_active,
  input wire logic core_trace_valid,
  input wire tcctl_pkg::tcctl_rec_t core_trace_outputs,
  output logic core_trace_ready,
  // Triggers
  input wire logic trig_start,
  input wire logic trig_stop,
  // Off-chip stream
  output logic offchip_valid,
  output logic [63:0] offchip_word,
  input wire logic offchip_ready,
  output logic trace_clk_out,
  output logic [PINS-1:0] offchip_trace_pins
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 65536)
      $error("DEPTH must be a power of two from 2 to 65536");
    if (PINS != 4 && PINS != 8 && PINS != 16)
      $error("PINS must be 4, 8 or 16");
    if (!ONCHIP && !OFFCHIP)
      $error("At least one trace target must exist");
  end

  // Core cycles per trace clock half-period; faster ratios run at the 100 rate, half the core clock
  function automatic logic [3:0] ratio_cycles(input logic [2:0] cr);
    case (cr)
      3'h4: ratio_cycles = 4'h1;
      3'h5: ratio_cycles = 4'h2;
      3'h6: ratio_cycles = 4'h3;
      3'h7: ratio_cycles = 4'h4;
      default: ratio_cycles = 4'h1;
    endcase
  endfunction

  function automatic logic is_stall(input tcctl_pkg::tcctl_rec_t r);
    is_stall = (r.rec_type == tcctl_pkg::TCCTL_TYPE6 &&
                (r.subcode == tcctl_pkg::TCCTL_SUB_STALL_A ||
                 r.subcode == tcctl_pkg::TCCTL_SUB_STALL_B)) ||
               (r.rec_type == tcctl_pkg::TCCTL_TYPE1 && !r.multipipe);
  endfunction

  function automatic logic [63:0] ptr_bytes(input logic [AW-1:0] p);
    ptr_bytes = 64'(p) << tcctl_pkg::TCCTL_PTR_SHIFT;
  endfunction

  function automatic logic [3:0] cal_row(input logic [2:0] i);
    case (i)
      3'h0: cal_row = 4'hf;
      3'h1: cal_row = 4'h0;
      3'h2: cal_row = 4'ha;
      3'h3: cal_row = 4'h5;
      3'h4: cal_row = 4'h8;
      3'h5: cal_row = 4'h4;
      3'h6: cal_row = 4'h2;
      default: cal_row = 4'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [2:0] mode_q;
  logic on_q;
  logic [4:0] sel_q;
  logic wr_q, rm_q, tr_q, bf_q, cal_q, ca_q, ofc_q, en_q;
  logic [1:0] fill_q;
  logic [2:0] cr_q;
  logic [AW-1:0] rp_q, wp_q, sp_q;
  logic [AW:0] cnt_q, remain_q;
  logic [63:0] mem [DEPTH];
  tcctl_pkg::tcctl_state_t state_q;
  logic started_q;

  logic wr_a, wr_b, wr_d, tw_read, rm_start, ptr_write;
  assign wr_a = tap_update && tap_addr == tcctl_pkg::TCCTL_ADDR_CORE_CTL;
  assign wr_b = tap_update && tap_addr == tcctl_pkg::TCCTL_ADDR_OUT_CTL &&
                tap_wdata[tcctl_pkg::TCCTL_B_WE];
  assign wr_d = tap_update && tap_addr == tcctl_pkg::TCCTL_ADDR_DATA;
  // A scan always reads, so the pointer advances on permitted writes too
  assign tw_read = wr_d && sel_q == tcctl_pkg::TCCTL_SEL_TW && rm_q;
  assign ptr_write = wr_d && wr_q && sel_q == tcctl_pkg::TCCTL_SEL_RDP;
  assign rm_start = wr_b && tap_wdata[tcctl_pkg::TCCTL_B_RM] && !rm_q &&
                    !tap_wdata[tcctl_pkg::TCCTL_B_TR];

  ////////////////////////////////////////////////////////////////////////////
  // core_trace_input_control
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_q <= 1'b0;
      mode_q <= tcctl_pkg::TCCTL_MODE_RESET;
    end else if (wr_a) begin
      on_q <= tap_wdata[tcctl_pkg::TCCTL_A_ON];
      mode_q <= tap_wdata[tcctl_pkg::TCCTL_A_MODE_LO +: 3];
    end
  end
  assign core_trace_on_input = on_q;
  assign core_trace_mode_input = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // trace_output_control plain fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_q <= 5'h00;
      wr_q <= 1'b0;
      fill_q <= tcctl_pkg::TCCTL_FILL_TO;
      cr_q <= tcctl_pkg::TCCTL_CR_RESET;
      cal_q <= 1'b0;
      ca_q <= 1'b0;
      ofc_q <= OFFCHIP && !ONCHIP;
    end else if (wr_b) begin
      sel_q <= tap_wdata[tcctl_pkg::TCCTL_B_SEL_LO +: 5];
      wr_q <= tap_wdata[tcctl_pkg::TCCTL_B_WR];
      fill_q <= tap_wdata[tcctl_pkg::TCCTL_B_FILL_LO +: 2];
      cr_q <= tap_wdata[tcctl_pkg::TCCTL_B_CR_LO +: 3];
      cal_q <= tap_wdata[tcctl_pkg::TCCTL_B_CAL];
      ca_q <= tap_wdata[tcctl_pkg::TCCTL_B_CA];
      if (ONCHIP && OFFCHIP)
        ofc_q <= tap_wdata[tcctl_pkg::TCCTL_B_OFC];
    end
  end

  // Master enable: register write, start and stop triggers; stop wins
  always_ff @(posedge clock) begin
    if (!rst_n)
      en_q <= 1'b0;
    else if (trig_stop)
      en_q <= 1'b0;
    else if (wr_b)
      en_q <= tap_wdata[tcctl_pkg::TCCTL_B_EN];
    else if (trig_start)
      en_q <= 1'b1;
  end

  // Memory reset pulse is visible for one cycle, then self-clears
  always_ff @(posedge clock) begin
    if (!rst_n)
      tr_q <= 1'b0;
    else
      tr_q <= wr_b && tap_wdata[tcctl_pkg::TCCTL_B_TR];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rm_q <= 1'b0;
      remain_q <= '0;
    end else if (tr_q) begin
      rm_q <= 1'b0;
      remain_q <= '0;
    end else if (rm_start) begin
      rm_q <= cnt_q != '0;
      remain_q <= cnt_q;
    end else if (tw_read) begin
      remain_q <= remain_q - 1'b1;
      if (remain_q == (AW+1)'(1))
        rm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record path: filter, two-entry buffer
  logic in_valid, in_ready, out_valid, out_ready, keep;
  logic [63:0] in_word, out_word;
  logic [63:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q, buf_wr_q;

  always_ff @(posedge clock) begin
    if (!rst_n)
      state_q <= tcctl_pkg::TCCTL_IDLE;
    else
      case (state_q)
        tcctl_pkg::TCCTL_IDLE:
          if (en_q) state_q <= tcctl_pkg::TCCTL_RUN;
        tcctl_pkg::TCCTL_RUN:
          if (trig_stop) state_q <= tcctl_pkg::TCCTL_STOPREC;
          else if (!en_q) state_q <= tcctl_pkg::TCCTL_IDLE;
        tcctl_pkg::TCCTL_STOPREC:
          if (in_ready) state_q <= tcctl_pkg::TCCTL_IDLE;
        default: state_q <= tcctl_pkg::TCCTL_IDLE;
      endcase
  end

  assign keep = ca_q || !is_stall(core_trace_outputs);
  always_comb begin
    in_valid = 1'b0;
    in_word = core_trace_outputs.word;
    if (!ca_q)
      in_word[0] = 1'b0;
    if (state_q == tcctl_pkg::TCCTL_STOPREC) begin
      in_valid = 1'b1;
      in_word = tcctl_pkg::TCCTL_STOP_WORD;
    end else if (state_q == tcctl_pkg::TCCTL_RUN && en_q) begin
      in_valid = core_trace_valid && keep;
    end
  end
  // Dropped or ignored records are consumed so the core never hangs
  assign core_trace_ready = (state_q == tcctl_pkg::TCCTL_RUN && en_q) ?
                            (in_ready || !keep) : 1'b1;

  assign in_ready = buf_cnt_q != 2'd2;
  assign out_valid = buf_cnt_q != 2'd0;
  assign out_word = buf_q[buf_rd_q];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_cnt_q <= 2'd0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_q[buf_wr_q] <= in_word;
        buf_wr_q <= !buf_wr_q;
      end
      if (out_valid && out_ready)
        buf_rd_q <= !buf_rd_q;
      buf_cnt_q <= buf_cnt_q + 2'(in_valid && in_ready) -
                   2'(out_valid && out_ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target selection and on-chip memory
  logic mem_we, from_block;
  assign from_block = fill_q == tcctl_pkg::TCCTL_FILL_FROM &&
                      (bf_q || !started_q);
  assign out_ready = ofc_q ? offchip_ready : 1'b1;
  assign mem_we = !ofc_q && out_valid && !from_block && !tr_q;
  assign offchip_valid = ofc_q && out_valid;
  assign offchip_word = out_word;

  always_ff @(posedge clock) begin
    if (!rst_n)
      started_q <= 1'b0;
    else if (tr_q || !en_q)
      started_q <= 1'b0;
    else if (core_tracing_active)
      started_q <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (mem_we)
      mem[wp_q] <= out_word;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_q <= '0;
      sp_q <= '0;
      cnt_q <= '0;
      bf_q <= 1'b0;
    end else if (tr_q) begin
      wp_q <= '0;
      sp_q <= '0;
      cnt_q <= '0;
      bf_q <= 1'b0;
    end else if (mem_we) begin
      wp_q <= wp_q + 1'b1;
      if (cnt_q == (AW+1)'(DEPTH)) begin
        sp_q <= sp_q + 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == (AW+1)'(DEPTH - 1) &&
            fill_q == tcctl_pkg::TCCTL_FILL_FROM)
          bf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      rp_q <= '0;
    else if (tr_q)
      rp_q <= '0;
    else if (rm_start)
      rp_q <= sp_q;
    else if (tw_read)
      rp_q <= rp_q + 1'b1;
    else if (ptr_write)
      rp_q <= tap_wdata[tcctl_pkg::TCCTL_PTR_SHIFT +: AW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back, captured before the update takes effect
  logic [63:0] ctl_a, ctl_b, cfg, ind;
  always_comb begin
    ctl_a = '0;
    ctl_a[tcctl_pkg::TCCTL_A_ON] = on_q;
    ctl_a[tcctl_pkg::TCCTL_A_MODE_LO +: 3] = mode_q;
    ctl_a[tcctl_pkg::TCCTL_A_SUPP_LO +: 2] = supported_modes;
    ctl_b = '0;
    ctl_b[tcctl_pkg::TCCTL_B_SEL_LO +: 5] = sel_q;
    ctl_b[tcctl_pkg::TCCTL_B_WR] = wr_q;
    ctl_b[tcctl_pkg::TCCTL_B_RM] = rm_q;
    ctl_b[tcctl_pkg::TCCTL_B_TR] = tr_q;
    ctl_b[tcctl_pkg::TCCTL_B_BF] = bf_q;
    ctl_b[tcctl_pkg::TCCTL_B_FILL_LO +: 2] = fill_q;
    ctl_b[tcctl_pkg::TCCTL_B_CR_LO +: 3] = cr_q;
    ctl_b[tcctl_pkg::TCCTL_B_CAL] = cal_q;
    ctl_b[tcctl_pkg::TCCTL_B_CA] = ca_q;
    ctl_b[tcctl_pkg::TCCTL_B_OFC] = ofc_q;
    ctl_b[tcctl_pkg::TCCTL_B_EN] = en_q;
    cfg = '0;
    cfg[tcctl_pkg::TCCTL_CFG_SZ_LO +: 4] = 4'(AW + 3 - 8);
    cfg[tcctl_pkg::TCCTL_CFG_ONT] = ONCHIP;
    cfg[tcctl_pkg::TCCTL_CFG_OFT] = OFFCHIP;
    case (sel_q)
      tcctl_pkg::TCCTL_SEL_CONFIG: ind = cfg;
      tcctl_pkg::TCCTL_SEL_TW: ind = rm_q ? mem[rp_q] : '0;
      tcctl_pkg::TCCTL_SEL_RDP: ind = ptr_bytes(rp_q);
      tcctl_pkg::TCCTL_SEL_WRP: ind = ptr_bytes(wp_q);
      tcctl_pkg::TCCTL_SEL_STP: ind = ptr_bytes(sp_q);
      default: ind = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tap_rdata <= '0;
      tap_rvalid <= 1'b0;
    end else begin
      tap_rvalid <= tap_update;
      if (tap_update)
        case (tap_addr)
          tcctl_pkg::TCCTL_ADDR_CORE_CTL: tap_rdata <= ctl_a;
          tcctl_pkg::TCCTL_ADDR_OUT_CTL: tap_rdata <= ctl_b;
          tcctl_pkg::TCCTL_ADDR_DATA: tap_rdata <= ind;
          default: tap_rdata <= '0;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trace clock divider and calibration pattern
  logic [3:0] div_q;
  logic tick;
  logic [2:0] cal_idx_q;
  assign tick = div_q >= ratio_cycles(cr_q) - 4'h1;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      trace_clk_out <= 1'b0;
    end else if (tick) begin
      div_q <= 4'h0;
      trace_clk_out <= !trace_clk_out;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cal_idx_q <= 3'h0;
      offchip_trace_pins <= '0;
    end else if (!cal_q) begin
      cal_idx_q <= 3'h0;
      offchip_trace_pins <= '0;
    end else if (tick && trace_clk_out) begin
      cal_idx_q <= cal_idx_q + 3'h1;
      offchip_trace_pins <= {(PINS/4){cal_row(cal_idx_q)}};
    end
  end
endmodule
`default_nettype wire

// [test/tcctl_regs_sva.sv]
/*
 Concurrent checks on the trace capture control register ports.
 Assumes it is bound to tcctl_regs and sees nothing but its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tcctl_regs_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // TAP data path
  input wire logic tap_update,
  input wire logic [7:0] tap_addr,
  input wire logic [63:0] tap_wdata,
  input wire logic [63:0] tap_rdata,
  input wire logic tap_rvalid,
  // Core controls and stream
  input wire logic [2:0] core_trace_mode_input,
  input wire logic core_trace_on_input,
  input wire logic offchip_valid,
  input wire logic [63:0] offchip_word,
  input wire logic offchip_ready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_out_rd;
    tap_rvalid && $past(tap_addr) == tcctl_pkg::TCCTL_ADDR_OUT_CTL;
  endsequence
  sequence s_core_wr;
    tap_update && tap_addr == tcctl_pkg::TCCTL_ADDR_CORE_CTL;
  endsequence
  property p_answer;
    tap_update |=> tap_rvalid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("tap access not answered");
  property p_pulse;
    !tap_update |=> !tap_rvalid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("tap answer without access");
  property p_rd_hold;
    !tap_update |=> $stable(tap_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("tap read data moved");
  property p_we_zero;
    s_out_rd |-> !tap_rdata[31];
  endproperty
  a_we_zero: assert property (p_we_zero)
    else $error("write enable read back set");
  property p_rsvd;
    s_out_rd |-> {tap_rdata[63:32], tap_rdata[27:26], tap_rdata[19:17],
      tap_rdata[11], tap_rdata[6:3]} == '0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  property p_on;
    s_core_wr |=> core_trace_on_input == $past(tap_wdata[0]);
  endproperty
  a_on: assert property (p_on)
    else $error("trace on output wrong");
  property p_mode;
    s_core_wr |=> core_trace_mode_input == $past(tap_wdata[3:1]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("trace mode output wrong");
  property p_ctl_hold;
    !(tap_update && tap_addr == tcctl_pkg::TCCTL_ADDR_CORE_CTL) |=>
      $stable(core_trace_on_input) && $stable(core_trace_mode_input);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("core controls moved without write");
  property p_stall;
    offchip_valid && !offchip_ready |=> offchip_valid && $stable(offchip_word);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stream word lost in stall");
  c_out: cover property (s_out_rd);
  c_stall: cover property (offchip_valid && !offchip_ready);
  c_move: cover property (offchip_valid && offchip_ready);
endmodule
bind tcctl_regs tcctl_regs_sva i_sva (
  .clock(clock),
  .rst_n(rst_n),
  .tap_update(tap_update),
  .tap_addr(tap_addr),
  .tap_wdata(tap_wdata),
  .tap_rdata(tap_rdata),
  .tap_rvalid(tap_rvalid),
  .core_trace_mode_input(core_trace_mode_input),
  .core_trace_on_input(core_trace_on_input),
  .offchip_valid(offchip_valid),
  .offchip_word(offchip_word),
  .offchip_ready(offchip_ready)
);
`default_nettype wire

// [test/tcctl_far_model.sv]
/*
 Core trace source and off-chip receiver facing the control block.
 Assumes the bench calls send and idle and drives stall at negedges.
*/
`timescale 1ns/1ps
`default_nettype none
module tcctl_far_model (
  // Clock
  input wire logic clock,
  // Core side
  output logic [1:0] supported_modes,
  output logic core_tracing_active,
  output logic core_trace_valid,
  output tcctl_pkg::tcctl_rec_t core_trace_outputs,
  input wire logic core_trace_ready,
  // Off-chip receiver
  input wire logic offchip_valid,
  input wire logic [63:0] offchip_word,
  output logic offchip_ready,
  input wire logic stall
);
  logic [63:0] got_q [$];
  initial begin
    // Full support so every mode encoding is legal
    supported_modes = 2'h2;
    core_tracing_active = 1'b1;
    core_trace_valid = 1'b0;
    core_trace_outputs = '1;
  end
  assign offchip_ready = !stall;
  always @(posedge clock) begin
    if (offchip_valid && offchip_ready) begin
      got_q.push_back(offchip_word);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Ready is read at the negedge, so the record is taken at the next posedge
  task automatic send(input tcctl_pkg::tcctl_rec_t r);
    @(negedge clock);
    core_trace_valid = 1'b1;
    core_trace_outputs = r;
    for (int n = 0; n < 64 && core_trace_ready !== 1'b1; n++) begin
      @(negedge clock);
    end
    @(posedge clock);
  endtask
  // Released lines show garbage, never the last record
  task automatic idle;
    @(negedge clock);
    core_trace_valid = 1'b0;
    core_trace_outputs = ~core_trace_outputs;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
/*
 Self-checking bench for the trace capture control registers.
 Assumes the far model stands in for the core and the probe receiver.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] A_CORE = tcctl_pkg::TCCTL_ADDR_CORE_CTL;
  localparam logic [7:0] A_OUT = tcctl_pkg::TCCTL_ADDR_OUT_CTL;
  localparam logic [7:0] A_DATA = tcctl_pkg::TCCTL_ADDR_DATA;
  logic clock, rst_n, tap_update, trig_start, trig_stop, stall, seen_full, lc;
  logic [7:0] tap_addr;
  logic [63:0] tap_wdata, rd;
  logic [3:0] lp;
  logic [8:0] desc [6];
  logic [63:0] exp_tw [5];
  int fail_count, compares, n, h;
  wire logic [63:0] tap_rdata, offchip_word;
  wire logic tap_rvalid, core_trace_on_input, core_trace_valid;
  wire logic core_trace_ready, core_tracing_active, offchip_valid;
  wire logic offchip_ready, trace_clk_out;
  wire logic [1:0] supported_modes;
  wire logic [2:0] core_trace_mode_input;
  wire logic [3:0] offchip_trace_pins;
  wire tcctl_pkg::tcctl_rec_t core_trace_outputs;
  tcctl_regs #(.DEPTH(8)) i_dut (
    .clock(clock), .rst_n(rst_n), .tap_update(tap_update),
    .tap_addr(tap_addr), .tap_wdata(tap_wdata), .tap_rdata(tap_rdata),
    .tap_rvalid(tap_rvalid), .supported_modes(supported_modes),
    .core_trace_mode_input(core_trace_mode_input),
    .core_trace_on_input(core_trace_on_input),
    .core_tracing_active(core_tracing_active),
    .core_trace_valid(core_trace_valid),
    .core_trace_outputs(core_trace_outputs),
    .core_trace_ready(core_trace_ready), .trig_start(trig_start),
    .trig_stop(trig_stop), .offchip_valid(offchip_valid),
    .offchip_word(offchip_word), .offchip_ready(offchip_ready),
    .trace_clk_out(trace_clk_out), .offchip_trace_pins(offchip_trace_pins));
  tcctl_far_model i_far (
    .clock(clock), .supported_modes(supported_modes),
    .core_tracing_active(core_tracing_active),
    .core_trace_valid(core_trace_valid),
    .core_trace_outputs(core_trace_outputs),
    .core_trace_ready(core_trace_ready), .offchip_valid(offchip_valid),
    .offchip_word(offchip_word), .offchip_ready(offchip_ready),
    .stall(stall));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(negedge clock) begin
    if (!rst_n) begin
      seen_full <= 1'b0;
    end else if (core_trace_ready === 1'b0) begin
      seen_full <= 1'b1;
    end
  end
  task automatic chk(input string s, input logic [63:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // One access; rd holds the register value from before the write
  task automatic tap(input logic [7:0] a, input logic [63:0] w);
    @(negedge clock);
    tap_update = 1'b1;
    tap_addr = a;
    tap_wdata = w;
    @(negedge clock);
    tap_update = 1'b0;
    rd = tap_rdata;
  endtask
  task automatic pulse(input bit stop);
    @(negedge clock);
    trig_start = !stop;
    trig_stop = stop;
    @(negedge clock);
    trig_start = 1'b0;
    trig_stop = 1'b0;
  endtask
  task automatic conclude;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {tap_update, trig_start, trig_stop, stall} = '0;
    tap_addr = 8'h00;
    tap_wdata = 64'h0;
    rst_n = 1'b0;
    fail_count = 0;
    compares = 0;
    desc = '{9'h040, 9'h0c2, 9'h040, 9'h021, 9'h0ca, 9'h020};
    exp_tw = '{64'h10, 64'h30, 64'h40, tcctl_pkg::TCCTL_STOP_WORD, 64'h0};
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    tap(A_OUT, 64'h0);
    chk("out reset", 64'h400, rd & 64'h8fff_ffff);
    tap(A_CORE, 64'h0);
    chk("core reset", 64'h0200_0000, rd & 64'h0300_000f);
    for (int m = 0; m < 8; m++) begin
      tap(A_CORE, 64'(m * 2 + 1));
      chk("mode", 64'(m), 64'(core_trace_mode_input));
      chk("trace on", 64'h1, 64'(core_trace_on_input));
    end
    tap(A_CORE, 64'h0);
    chk("trace off", 64'h0, 64'(core_trace_on_input));
    tap(A_OUT, 64'h3);
    tap(A_OUT, 64'h0);
    chk("no enable", 64'h400, rd & 64'h8fff_ffff);
    tap(A_OUT, 64'h8c0e_0c78);
    tap(A_OUT, 64'h0);
    chk("reserved", 64'h400, rd & 64'h8fff_ffff);
    tap(8'h13, 64'h0);
    chk("unmapped", 64'h0, rd);
    tap(A_OUT, 64'h83e0_0400);
    tap(A_OUT, 64'h0);
    chk("select", 64'h03e0_0400, rd & 64'h8fff_ffff);
    for (int cr = 0; cr < 8; cr++) begin
      tap(A_OUT, 64'h8000_0000 | 64'(cr) << 8);
      repeat (10) @(negedge clock);
      h = (cr < 4) ? 1 : cr - 3;
      n = 0;
      lc = trace_clk_out;
      repeat (24) begin
        @(negedge clock);
        if (trace_clk_out !== lc) n++;
        lc = trace_clk_out;
      end
      chk("clock toggles", 64'(24 / h), 64'(n));
    end
    tap(A_OUT, 64'h8000_0480);
    for (n = 0; n < 64 && offchip_trace_pins !== 4'hf; n++) @(negedge clock);
    for (int k = 1; k < 8; k++) begin
      lp = offchip_trace_pins;
      for (n = 0; n < 64 && offchip_trace_pins === lp; n++) @(negedge clock);
      chk("cal row", 64'((32'hf0a5_8421 >> (28 - 4 * k)) & 32'hf),
        64'(offchip_trace_pins));
    end
    // Capture to on-chip memory with stall records dropped
    tap(A_OUT, 64'h8000_8400);
    pulse(1'b0);
    tap(A_OUT, 64'h0);
    chk("start", 64'h1, rd & 64'h1);
    for (int i = 0; i < 6; i++) begin
      i_far.send(tcctl_pkg::tcctl_rec_t'({desc[i], 64'(i * 16 + 17)}));
    end
    i_far.idle();
    repeat (4) @(negedge clock);
    pulse(1'b1);
    repeat (8) @(negedge clock);
    tap(A_OUT, 64'h80c0_0400);
    chk("stopped", 64'h0, rd & 64'h1);
    tap(A_DATA, 64'h0);
    chk("write ptr", 64'h20, rd);
    tap(A_OUT, 64'h8081_0400);
    for (int i = 0; i < 5; i++) begin
      tap(A_DATA, 64'h0);
      chk("trace word", exp_tw[i], rd);
    end
    tap(A_OUT, 64'h80c0_8400);
    chk("read done", 64'h0, rd & 64'h1_0000);
    tap(A_DATA, 64'h0);
    chk("ptr reset", 64'h0, rd);
    tap(A_OUT, 64'h0);
    chk("reset done", 64'h0, rd & 64'h1_c000);
    // Off-chip stream with the receiver stalling
    tap(A_OUT, 64'h8000_0407);
    @(negedge clock);
    stall = 1'b1;
    fork
      begin
        for (int i = 0; i < 3; i++) begin
          i_far.send(tcctl_pkg::tcctl_rec_t'({(i == 1) ? 9'h0c2 : 9'h040,
            64'(i * 16 + 81)}));
        end
        i_far.idle();
      end
      begin
        repeat (12) @(negedge clock);
        stall = 1'b0;
      end
    join
    repeat (10) @(negedge clock);
    chk("buffer full", 64'h1, 64'(seen_full));
    chk("stream count", 64'h3, 64'(i_far.got_q.size()));
    for (int i = 0; i < 3; i++) begin
      chk("stream word", 64'(i * 16 + 81), i_far.got_q[i]);
    end
    // Trace-from fill stops once the memory holds DEPTH words
    tap(A_OUT, 64'h8000_9401);
    for (int i = 0; i < 9; i++) begin
      i_far.send(tcctl_pkg::tcctl_rec_t'({9'h040, 64'(i * 16)}));
    end
    i_far.idle();
    repeat (6) @(negedge clock);
    tap(A_OUT, 64'h80b0_0400);
    chk("buffer full bit", 64'h4000, rd & 64'h4000);
    tap(A_DATA, 64'h18);
    tap(A_DATA, 64'h0);
    chk("read ptr write", 64'h18, rd);
    conclude();
  end
endmodule
`default_nettype wire
